// ==== rtl/sadc_consts.vh ====
// Constants for the serial ADC conversion interface
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
`define SADC_CTL_START 7
`define SADC_CTL_CH_HI 6
`define SADC_CTL_CH_LO 4
`define SADC_CTL_POL 3
`define SADC_CTL_CFG 2
`define SADC_CTL_PWR 1
`define SADC_CTL_CLK 0
`define SADC_INT_CONV_NS 25000
`define SADC_CLK_NS 10
`define SADC_INT_CONV_CYC (`SADC_INT_CONV_NS / `SADC_CLK_NS)
`define SADC_FIFO_DEPTH 16
`endif

// ==== rtl/sadc_fifo.v ====
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output reg [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire [AW:0] count = wrPtr_q - rdPtr_q;
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  always @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
      if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
  always @(posedge sys_clk) begin
    if (doWr) mem[wrPtr_q[AW-1:0]] <= inData;
  end
  always @* begin
    outData = mem[rdPtr_q[AW-1:0]];
  end
endmodule
`default_nettype wire

// ==== rtl/sadc_core.v ====
// Serial command and readout logic of an 8-bit multi-channel SAR ADC
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"
module sadc_core #(
  parameter INT_CONV_CYC = `SADC_INT_CONV_CYC
) (
  input wire sys_clk,
  input wire rst,
  input wire csN,
  input wire serialClk,
  input wire serialIn,
  output reg serialOut,
  output reg serialOutEnN,
  output reg conversionStrobe,
  output reg conversionStrobeEnN,
  input wire [7:0] sampleIn,
  output wire [7:0] resultData,
  output wire resultValid,
  input wire resultReady,
  output reg [2:0] channelSel,
  output reg polaritySel,
  output reg inputConfigSel,
  output reg powerModeSel,
  output reg clockModeSel,
  output reg converting
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SHIFT = 3'h1;
  localparam ST_EXT = 3'h2;
  localparam ST_INT = 3'h3;
  localparam ST_HOLD = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] csSync_q;
  reg [1:0] sclkSync_q;
  reg [1:0] dinSync_q;
  reg sclkPrev_q;
  reg csPrev_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      csSync_q <= 2'h3;
      sclkSync_q <= 2'h0;
      dinSync_q <= 2'h0;
      sclkPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else begin
      csSync_q <= {csSync_q[0], csN};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      dinSync_q <= {dinSync_q[0], serialIn};
      sclkPrev_q <= sclkSync_q[1];
      csPrev_q <= csSync_q[1];
    end
  end
  wire csLow = ~csSync_q[1];
  wire sclkRise = sclkSync_q[1] & ~sclkPrev_q;
  wire sclkFall = ~sclkSync_q[1] & sclkPrev_q;
  wire csFallEv = csPrev_q & ~csSync_q[1];
  wire csRiseEv = ~csPrev_q & csSync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [2:0] state_q;
  reg [7:0] ctl_q;
  reg [2:0] ctlCnt_q;
  reg ctlDone_q;
  reg [3:0] convCnt_q;
  reg [7:0] outSh_q;
  reg [7:0] sar_q;
  reg startOk_q;
  reg csToggled_q;
  reg [31:0] intCnt_q;
  reg [1:0] intFalls_q;
  reg intReady_q;
  reg fifoPush_q;
  reg [7:0] fifoWord_q;
  wire fifoInReady;

  // Coding: straight binary unipolar, two's complement bipolar
  // Coding follows the polarity bit of the byte just received
  wire [7:0] coded = ctl_q[`SADC_CTL_POL] ? sampleIn :
                     (sampleIn ^ 8'h80);

  // A new start bit may arrive when idle, after MSB out, or after abort
  wire startWin = (state_q == ST_IDLE) || (state_q == ST_HOLD) ||
                  startOk_q || csToggled_q;

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ctl_q <= 8'h00;
      ctlCnt_q <= 3'h0;
      ctlDone_q <= 1'b0;
      convCnt_q <= 4'h0;
      outSh_q <= 8'h00;
      sar_q <= 8'h00;
      startOk_q <= 1'b0;
      csToggled_q <= 1'b0;
      intCnt_q <= 32'h0;
      intFalls_q <= 2'h0;
      intReady_q <= 1'b0;
      fifoPush_q <= 1'b0;
      fifoWord_q <= 8'h00;
      serialOut <= 1'b0;
      conversionStrobe <= 1'b1;
      channelSel <= 3'h0;
      polaritySel <= 1'b1;
      inputConfigSel <= 1'b1;
      powerModeSel <= 1'b1;
      clockModeSel <= 1'b0;
      converting <= 1'b0;
    end else begin
      fifoPush_q <= 1'b0;
      if (csRiseEv && converting && clockModeSel)
        csToggled_q <= 1'b1;
      if (csFallEv && clockModeSel)
        conversionStrobe <= 1'b0;
      // Control byte shifting on rising edges while selected
      if (csLow && sclkRise) begin
        if (ctlCnt_q == 3'h0 && !ctlDone_q) begin
          if (dinSync_q[1] && startWin) begin
            ctl_q <= 8'h01;
            ctlCnt_q <= 3'h1;
            startOk_q <= 1'b0;
          end
        end else if (!ctlDone_q) begin
          ctl_q <= {ctl_q[6:0], dinSync_q[1]};
          ctlCnt_q <= ctlCnt_q + 3'h1;
          if (ctlCnt_q == 3'h7)
            ctlDone_q <= 1'b1;
        end
      end
      // Conversion start only on the fall after the clock-mode bit
      if (sclkFall && ctlDone_q) begin
        ctlDone_q <= 1'b0;
        ctlCnt_q <= 3'h0;
        csToggled_q <= 1'b0;
        channelSel <= ctl_q[`SADC_CTL_CH_HI:`SADC_CTL_CH_LO];
        polaritySel <= ctl_q[`SADC_CTL_POL];
        inputConfigSel <= ctl_q[`SADC_CTL_CFG];
        powerModeSel <= ctl_q[`SADC_CTL_PWR];
        clockModeSel <= ctl_q[`SADC_CTL_CLK];
        converting <= 1'b1;
        sar_q <= coded;
        convCnt_q <= 4'h0;
        if (ctl_q[`SADC_CTL_CLK]) begin
          state_q <= ST_EXT;
          conversionStrobe <= 1'b1;
          serialOut <= 1'b0;
        end else begin
          state_q <= ST_INT;
          intCnt_q <= 32'h0;
          intReady_q <= 1'b0;
          conversionStrobe <= 1'b0;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (sclkFall) serialOut <= 1'b0;
          end
          ST_SHIFT: begin
            state_q <= ST_IDLE;
          end
          ST_EXT: begin
            // Strobe for two falls, then eight result bits, then zeros
            if (sclkFall) begin
              convCnt_q <= convCnt_q + 4'h1;
              if (convCnt_q == 4'h0) begin
                conversionStrobe <= 1'b1;
              end else if (convCnt_q == 4'h1) begin
                conversionStrobe <= 1'b0;
                serialOut <= sar_q[7];
                outSh_q <= {sar_q[6:0], 1'b0};
                startOk_q <= 1'b1;
              end else if (convCnt_q < 4'h9) begin
                serialOut <= outSh_q[7];
                outSh_q <= {outSh_q[6:0], 1'b0};
                if (convCnt_q == 4'h8) begin
                  converting <= 1'b0;
                  fifoPush_q <= 1'b1;
                  fifoWord_q <= sar_q;
                  state_q <= ST_HOLD;
                end
              end
            end
            if (csRiseEv && convCnt_q < 4'h8) begin
              state_q <= ST_IDLE;
              converting <= 1'b0;
            end
          end
          ST_INT: begin
            // Conversion on the internal clock, not disturbed by deselect
            if (!intReady_q) begin
              intCnt_q <= intCnt_q + 32'h1;
              if (intCnt_q >= INT_CONV_CYC - 1) begin
                intReady_q <= 1'b1;
                conversionStrobe <= 1'b1;
                converting <= 1'b0;
                intFalls_q <= 2'h0;
                fifoPush_q <= 1'b1;
                fifoWord_q <= sar_q;
              end
            end else if (sclkFall) begin
              if (intFalls_q == 2'h0) begin
                intFalls_q <= 2'h1;
              end else if (intFalls_q == 2'h1) begin
                intFalls_q <= 2'h2;
                serialOut <= sar_q[7];
                outSh_q <= {sar_q[6:0], 1'b0};
                convCnt_q <= 4'h1;
                startOk_q <= 1'b1;
              end else begin
                serialOut <= outSh_q[7];
                outSh_q <= {outSh_q[6:0], 1'b0};
                convCnt_q <= convCnt_q + 4'h1;
                if (convCnt_q == 4'h7) state_q <= ST_HOLD;
              end
            end
          end
          ST_HOLD: begin
            if (sclkFall) serialOut <= 1'b0;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enables (low while driving)
  always @(posedge sys_clk) begin
    if (rst) begin
      serialOutEnN <= 1'b1;
      conversionStrobeEnN <= 1'b0;
    end else begin
      serialOutEnN <= ~csLow;
      conversionStrobeEnN <= clockModeSel & ~csLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result buffering
  sadc_fifo #(
    .WIDTH(8),
    .DEPTH(`SADC_FIFO_DEPTH),
    .AW(4)
  ) resultFifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inData(fifoWord_q),
    .inValid(fifoPush_q),
    .inReady(fifoInReady),
    .outData(resultData),
    .outValid(resultValid),
    .outReady(resultReady)
  );
  wire unusedReady = fifoInReady;
endmodule
`default_nettype wire

// ==== verif/sadc_asserts.sv ====
// Port assertions for the serial ADC interface core
`timescale 1ns/1ps
`default_nettype none
module sadc_asserts #(
  parameter INT_CONV_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  input wire logic conversionStrobe,
  input wire logic conversionStrobeEnN,
  input wire logic clockModeSel,
  input wire logic converting
);
  int convCnt_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Cycles since the current conversion began
  always @(posedge sys_clk) begin
    if (rst || $rose(converting)) begin
      convCnt_q <= 0;
    end else if (convCnt_q < 9999) begin
      convCnt_q <= convCnt_q + 1;
    end
  end
////////////////////////////////////////////////////////////////////////////
  property p_rst;
    $fell(rst) |-> conversionStrobe && !serialOut && !clockModeSel;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
  property p_out_fall;
    !serialOutEnN && $past(!serialOutEnN) && $changed(serialOut) |-> !serialClk;
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("data moved outside clock low");
  property p_stb_fall;
    clockModeSel && !conversionStrobeEnN && $changed(conversionStrobe)
      |-> !serialClk;
  endproperty
  a_stb_fall: assert property (p_stb_fall)
    else $error("strobe moved outside clock low");
  property p_start;
    $rose(converting) |-> !serialClk;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion began off a falling edge");
  property p_ext_float;
    (clockModeSel && csN)[*6] |-> serialOutEnN && conversionStrobeEnN;
  endproperty
  a_ext_float: assert property (p_ext_float)
    else $error("outputs driven while deselected");
  property p_int_float;
    (!clockModeSel && csN)[*6] |-> serialOutEnN && !conversionStrobeEnN;
  endproperty
  a_int_float: assert property (p_int_float)
    else $error("wrong enables while deselected");
  property p_int_low;
    $rose(converting) |-> ##[0:3] (clockModeSel || !conversionStrobe);
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("strobe not low at conversion start");
  property p_int_len;
    $rose(conversionStrobe) && !clockModeSel
      |-> convCnt_q >= INT_CONV_CYC - 4 && convCnt_q <= INT_CONV_CYC + 4;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("internal conversion length wrong");
  property p_ext_pulse;
    $rose(conversionStrobe) && clockModeSel && !csN
      |-> (conversionStrobe || conversionStrobeEnN)[*8] ##[12:20] !conversionStrobe;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("strobe pulse length wrong");
endmodule
`default_nettype wire

// ==== verif/sadc_spi_host.sv ====
// SPI master model driving chip select, serial clock and command input
`timescale 1ns/1ps
`default_nettype none
module sadc_spi_host (
  output logic csN,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialOut
);
  realtime half = 62.5;
  initial begin
    csN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // Clock idles low; data set while low, both sides sample on the rise
  task automatic shift(input int n, input logic [31:0] tx,
                       output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = tx[i];
      #(half) serialClk = 1'b1;
      rx = {rx[30:0], serialOut};
      #(half) serialClk = 1'b0;
    end
    serialIn = ~serialIn;
  endtask
  task automatic select(input logic lvl);
    #(half) csN = lvl;
    #(half);
  endtask
endmodule
`default_nettype wire

// ==== verif/sadc_tb.sv ====
// Self-checking bench for the serial ADC interface core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic resultReady = 1'b0;
  logic [7:0] sampleIn = 8'h00;
  wire csN, serialClk, serialIn, serialOut, serialOutEnN, conversionStrobe;
  wire conversionStrobeEnN, resultValid, polaritySel, inputConfigSel;
  wire powerModeSel, clockModeSel, converting;
  wire [7:0] resultData;
  wire [2:0] channelSel;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] lfsr = 32'hd047;
  logic [31:0] rx;
  logic [7:0] r, ctl;
  logic [7:0] q[$];
  always #5 sys_clk = ~sys_clk;
  sadc_core #(.INT_CONV_CYC(20)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .csN(csN), .serialClk(serialClk), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .conversionStrobe(conversionStrobe),
    .conversionStrobeEnN(conversionStrobeEnN), .sampleIn(sampleIn),
    .resultData(resultData), .resultValid(resultValid),
    .resultReady(resultReady), .channelSel(channelSel),
    .polaritySel(polaritySel), .inputConfigSel(inputConfigSel),
    .powerModeSel(powerModeSel), .clockModeSel(clockModeSel),
    .converting(converting));
  sadc_spi_host host_u (.csN(csN), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut));
////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] code(input logic [7:0] s, input logic uni);
    return uni ? s : s ^ 8'h80;
  endfunction
  task automatic stepRand();
    @(posedge sys_clk);
    #1 lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    sampleIn = lfsr[7:0];
  endtask
  task automatic single(input logic [7:0] c, input logic lead);
    r = code(sampleIn, c[3]);
    host_u.select(1'b0);
    if (lead) host_u.shift(8, 32'h0, rx);
    host_u.shift(24, {8'h0, c, 16'h0}, rx);
    host_u.select(1'b1);
    check("rx", rx[15:0], {2'b00, r, 6'b0});
    check("ctl", {channelSel, polaritySel, inputConfigSel, powerModeSel,
      clockModeSel}, c[6:0]);
    if (q.size() < 16) q.push_back(r);
  endtask
  task automatic drain(input int n);
    int got;
    logic fire;
    logic [7:0] d;
    got = 0;
    fire = 1'b0;
    for (int k = 0; k < 600 && got < n; k++) begin
      stepRand();
      if (fire) begin
        check("fifo", d, q.pop_front());
        got++;
      end
      resultReady = (got < n) && lfsr[9];
      fire = resultReady && (resultValid === 1'b1);
      d = resultData;
    end
    check("count", got, n);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    host_u.select(1'b0);
    host_u.shift(8, 32'h0, rx);
    check("zeros", rx[7:0], 8'h00);
    host_u.select(1'b1);
    for (int i = 0; i < 18; i++) begin
      stepRand();
      single({1'b1, lfsr[14:12], lfsr[9:8], 2'b11}, i[0]);
    end
    drain(16);
    check("empty", resultValid, 1'b0);
    $display("external mode and buffer done");
    for (int j = 0; j < 2; j++) begin
      stepRand();
      ctl = j ? 8'hd6 : 8'h9e;
      host_u.select(1'b0);
      host_u.shift(8, {24'h0, ctl}, rx);
      host_u.select(1'b1);
      check("busy", {conversionStrobe, conversionStrobeEnN, serialOutEnN},
        3'b001);
      repeat (30) @(posedge sys_clk);
      #1 check("done", conversionStrobe, 1'b1);
      host_u.select(1'b0);
      host_u.shift(16, 32'h0, rx);
      host_u.select(1'b1);
      r = code(sampleIn, ctl[3]);
      check("int rx", rx[13:6], r);
      q.push_back(r);
      drain(1);
    end
    $display("internal mode done");
    host_u.select(1'b0);
    for (int f = 0; f < 4; f++) begin
      stepRand();
      host_u.shift(10, {22'h0, (f < 3) ? 8'hff : 8'h00, 2'b00}, rx);
      if (f > 0) check("overlap", rx[9:0], {r, 2'b00});
      r = sampleIn;
    end
    host_u.select(1'b1);
    $display("overlapped frames done");
    stepRand();
    host_u.select(1'b0);
    host_u.shift(8, 32'hff, rx);
    host_u.select(1'b1);
    check("float", {serialOutEnN, conversionStrobeEnN}, 2'b11);
    host_u.select(1'b0);
    check("stb low", {conversionStrobe, conversionStrobeEnN}, 2'b00);
    stepRand();
    host_u.shift(24, {8'h0, 8'hff, 16'h0}, rx);
    host_u.select(1'b1);
    check("abort rx", rx[15:0], {2'b00, sampleIn, 6'b0});
    $display("abort done");
    report_and_stop();
  end
endmodule
bind sadc_core sadc_asserts #(.INT_CONV_CYC(INT_CONV_CYC)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .csN(csN), .serialClk(serialClk),
  .serialOut(serialOut), .serialOutEnN(serialOutEnN),
  .conversionStrobe(conversionStrobe),
  .conversionStrobeEnN(conversionStrobeEnN),
  .clockModeSel(clockModeSel), .converting(converting));
`default_nettype wire
